// file: logic/byte_ram.sv
// single port byte memory with registered read data
`default_nettype none
module byte_ram #(
  parameter int AW = 14
) (
  input  wire logic          aclk,   // clock
  input  wire logic          we,     // write enable
  input  wire logic [AW-1:0] addr,   // byte address
  input  wire logic [7:0]    wdata,  // write byte
  output logic      [7:0]    rdata   // read byte, one cycle late
);
  logic [7:0] mem [0:(1<<AW)-1];

  // read-before-write; contents are not reset, like real cells
  always_ff @(posedge aclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule
`default_nettype wire

// file: logic/flash_ctl_defs.svh
// offsets, field positions and timing constants of the flash controller
`ifndef FLASH_CTL_DEFS_SVH
`define FLASH_CTL_DEFS_SVH

// register byte offsets on the control bus
`define FCR_OFS        8'h00
`define ACR_OFS        8'h04

// flash control register fields
`define FCR_BUSY_BIT   0
`define FCR_MODE_LO    1
`define FCR_MODE_HI    2
`define FCR_LMAP_BIT   3
`define FCR_KEY_LO     4
`define FCR_KEY_HI     7
`define ACR_BOOT_BIT   0

// launch key nibbles
`define KEY_ARM        4'h5
`define KEY_GO         4'hA

// space select codes
`define SP_USER        2'b00
`define SP_EXTRA       2'b01
`define SP_SEC         2'b10

// code space decode limits
`define USER_TOP       16'h3FFF
`define BOOT_BASE      16'hF800
`define EXTRA_BASE     16'hFF80
`define SEC_ADDR       16'h0000

// security byte low nibble as left by parallel mode
`define SEC_LO_RESET   4'hF

// bus answers
`define RESP_OKAY      2'b00
`define RESP_SLVERR    2'b10

// instructions allowed to retire between the two key writes
`define MAX_RETIRE     2'd1

// timing: figures in ns, counts rounded up at the clock rate
`define CLK_MHZ        40
`define ERASE_TIME_NS  2000
`define PROG_TIME_NS   1000
`define ERASE_CYC      ((`ERASE_TIME_NS * `CLK_MHZ + 999) / 1000)
`define PROG_CYC       ((`PROG_TIME_NS * `CLK_MHZ + 999) / 1000)

`endif

// file: logic/flash_ctl_pkg.sv
// types shared by the flash page program controller
`default_nettype none
package flash_ctl_pkg;
  // program sequencer states
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_ERASE = 3'b001,
    S_FETCH = 3'b010,
    S_WRITE = 3'b011,
    S_PROG  = 3'b100,
    S_DONE  = 3'b101
  } seq_e;
  // source of a pending code read
  typedef enum logic [2:0] {
    SRC_USER = 3'b000,
    SRC_BOOT = 3'b001,
    SRC_EXTRA = 3'b010,
    SRC_SEC  = 3'b011,
    SRC_ERR  = 3'b100
  } src_e;
endpackage
`default_nettype wire

// file: logic/flash_page_program_control.sv
// flash page program controller: mapping, key launch, erase/program walk
`default_nettype none
`include "flash_ctl_defs.svh"
module flash_page_program_control (
  input  wire logic        aclk,            // clock, 40 MHz
  input  wire logic        aresetn,         // sync reset, active low
  input  wire logic [7:0]  s_axi_awaddr,    // write address
  input  wire logic        s_axi_awvalid,   // write address valid
  output logic             s_axi_awready,   // write address ready
  input  wire logic [31:0] s_axi_wdata,     // write data
  input  wire logic [3:0]  s_axi_wstrb,     // write strobes
  input  wire logic        s_axi_wvalid,    // write data valid
  output logic             s_axi_wready,    // write data ready
  output logic [1:0]       s_axi_bresp,     // write response
  output logic             s_axi_bvalid,    // write response valid
  input  wire logic        s_axi_bready,    // write response ready
  input  wire logic [7:0]  s_axi_araddr,    // read address
  input  wire logic        s_axi_arvalid,   // read address valid
  output logic             s_axi_arready,   // read address ready
  output logic [31:0]      s_axi_rdata,     // read data
  output logic [1:0]       s_axi_rresp,     // read response
  output logic             s_axi_rvalid,    // read data valid
  input  wire logic        s_axi_rready,    // read data ready
  input  wire logic        exec_from_boot,  // core fetches from boot flash
  input  wire logic        instr_retire,    // core finished an instruction
  input  wire logic        code_rd,         // code read request pulse
  input  wire logic [15:0] code_addr,       // code read address
  output logic [7:0]       code_rdata,      // code read byte
  output logic             code_rvalid,     // code read answer pulse
  output logic             code_rerr,       // code read not allowed
  input  wire logic        xdata_wr,        // external data write pulse
  input  wire logic [15:0] xdata_addr,      // external data address
  input  wire logic [7:0]  xdata_wdata,     // external data byte
  input  wire logic        eeprom_space_enable, // eeprom mapped for writes
  output logic             route_latch,     // pulse: write of the previous cycle went to latches
  output logic             route_eeprom,    // pulse: write of the previous cycle went to eeprom
  output logic             route_xram,      // pulse: write of the previous cycle went to xram
  output logic             flash_busy       // programming in progress
);
  import flash_ctl_pkg::*;

  typedef struct packed {
    logic        aw_got;
    logic [7:0]  aw_addr;
    logic        w_got;
    logic [7:0]  w_byte;
    logic        w_lane0;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [3:0]  key_nib;
    logic        lmap;
    logic [1:0]  mode;
    logic        busy;
    logic        boot_en;
    logic        armed;
    logic [1:0]  retire_cnt;
    seq_e        fsm;
    logic [1:0]  tgt;
    logic [7:0]  page;
    logic [6:0]  idx;
    logic [11:0] timer;
    logic        rd_pend;
    src_e        rd_src;
    logic        code_valid;
    logic [7:0]  code_data;
    logic        code_err;
    logic        r_latch;
    logic        r_eeprom;
    logic        r_xram;
    logic [3:0]  sec_hi;
  } state_s;

  state_s st_ff;
  state_s nxt_st;

  logic [7:0]  user_q;
  logic [7:0]  boot_q;
  logic [7:0]  extra_q;
  logic [7:0]  latch_q;
  logic        latch_loaded;
  logic [13:0] user_addr;
  logic        user_we;
  logic        extra_we;
  logic        latch_we;
  logic        latch_clear;
  logic        do_wr;
  logic        wr_fcr;
  logic        key_arm;
  logic        key_go;
  logic        launch_ok;
  logic [7:0]  wr_addr;
  logic [7:0]  fcr_now;
  src_e        dec_src;

  // code space decode; space select overrides the plain user map
  function automatic src_e decode(input logic [15:0] a, input logic [1:0] m,
                                  input logic boot_en, input logic from_boot);
    decode = SRC_ERR;
    if (m == `SP_EXTRA && a >= `EXTRA_BASE) begin
      decode = SRC_EXTRA;
    end else if (m == `SP_SEC && a == `SEC_ADDR) begin
      decode = SRC_SEC;
    end else if (m == `SP_USER && a <= `USER_TOP) begin
      decode = SRC_USER;
    end else if (boot_en && a >= `BOOT_BASE) begin
      decode = from_boot ? SRC_BOOT : SRC_ERR;
    end
  endfunction

  // memory arrays; the boot array has no software write path at all
  byte_ram #(.AW(14)) u_user (
    .aclk  (aclk),
    .we    (user_we),
    .addr  (user_addr),
    .wdata (latch_q),
    .rdata (user_q)
  );
  byte_ram #(.AW(11)) u_boot (
    .aclk  (aclk),
    .we    (1'b0),
    .addr  (code_addr[10:0]),
    .wdata (8'h00),
    .rdata (boot_q)
  );
  byte_ram #(.AW(7)) u_extra (
    .aclk  (aclk),
    .we    (extra_we),
    .addr  (st_ff.busy ? st_ff.idx : code_addr[6:0]),
    .wdata (latch_q),
    .rdata (extra_q)
  );
  latch_buffer #(.AW(7)) u_latch (
    .aclk    (aclk),
    .aresetn (aresetn),
    .we      (latch_we),
    .waddr   (xdata_addr[6:0]),
    .wdata   (xdata_wdata),
    .raddr   (st_ff.idx),
    .clear   (latch_clear),
    .rdata   (latch_q),
    .loaded  (latch_loaded)
  );

  // program walk writes only loaded bytes, into the page of the last latch load
  always_comb begin
    user_addr = st_ff.busy ? {st_ff.page[6:0], st_ff.idx} : code_addr[13:0];
    user_we = st_ff.fsm == S_WRITE && st_ff.tgt == `SP_USER
              && latch_loaded;
    extra_we = st_ff.fsm == S_WRITE && st_ff.tgt == `SP_EXTRA
              && latch_loaded;
    latch_we = xdata_wr && st_ff.lmap && !st_ff.busy;
    latch_clear = st_ff.fsm == S_DONE;
  end

  // bus write decode; the write fires once both halves are held
  always_comb begin
    wr_addr = st_ff.aw_got ? st_ff.aw_addr : s_axi_awaddr;
    do_wr = (st_ff.aw_got || (s_axi_awvalid && st_ff.awready))
            && (st_ff.w_got || (s_axi_wvalid && st_ff.wready))
            && !st_ff.bvalid;
    fcr_now = st_ff.w_got ? st_ff.w_byte : s_axi_wdata[7:0];
    wr_fcr = do_wr && wr_addr == `FCR_OFS
             && (st_ff.w_got ? st_ff.w_lane0 : s_axi_wstrb[0]);
    key_arm = wr_fcr && !st_ff.busy
              && fcr_now[`FCR_KEY_HI:`FCR_KEY_LO] == `KEY_ARM;
    key_go = wr_fcr && !st_ff.busy && st_ff.armed
             && fcr_now[`FCR_KEY_HI:`FCR_KEY_LO] == `KEY_GO;
    // launch needs boot execution and a defined space
    launch_ok = key_go && exec_from_boot
                && fcr_now[`FCR_MODE_HI:`FCR_MODE_LO] != 2'b11;
    dec_src = decode(code_addr, st_ff.mode, st_ff.boot_en, exec_from_boot);
  end

  // next state of bus slave, control register and sequencer
  always_comb begin
    nxt_st = st_ff;
    // capture write halves that arrive separately
    if (s_axi_awvalid && st_ff.awready && !do_wr) begin
      nxt_st.aw_got = 1'b1;
      nxt_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_ff.wready && !do_wr) begin
      nxt_st.w_got = 1'b1;
      nxt_st.w_byte = s_axi_wdata[7:0];
      nxt_st.w_lane0 = s_axi_wstrb[0];
    end
    if (do_wr) begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = (wr_addr == `FCR_OFS || wr_addr == `ACR_OFS)
                     ? `RESP_OKAY : `RESP_SLVERR;
    end else if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    // control fields; busy is hardware owned and never written
    if (wr_fcr) begin
      nxt_st.key_nib = fcr_now[`FCR_KEY_HI:`FCR_KEY_LO];
      nxt_st.lmap = fcr_now[`FCR_LMAP_BIT];
      nxt_st.mode = fcr_now[`FCR_MODE_HI:`FCR_MODE_LO];
    end
    if (do_wr && wr_addr == `ACR_OFS
        && (st_ff.w_got ? st_ff.w_lane0 : s_axi_wstrb[0])) begin
      nxt_st.boot_en = fcr_now[`ACR_BOOT_BIT];
    end
    // key pair: any other FCR write or a second retired instruction disarms
    if (key_arm) begin
      nxt_st.armed = 1'b1;
      nxt_st.retire_cnt = 2'd0;
    end else if (wr_fcr) begin
      nxt_st.armed = 1'b0;
    end else if (st_ff.armed && instr_retire) begin
      if (st_ff.retire_cnt >= `MAX_RETIRE) begin
        nxt_st.armed = 1'b0;
      end else begin
        nxt_st.retire_cnt = st_ff.retire_cnt + 2'd1;
      end
    end
    // bus read
    if (s_axi_arvalid && st_ff.arready) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = `RESP_OKAY;
      case (s_axi_araddr)
        `FCR_OFS: nxt_st.rdata = {24'h00_0000, st_ff.key_nib, st_ff.lmap,
                                  st_ff.mode, st_ff.busy};
        `ACR_OFS: nxt_st.rdata = {31'h0000_0000, st_ff.boot_en};
        default: begin
          nxt_st.rdata = 32'h0000_0000;
          nxt_st.rresp = `RESP_SLVERR;
        end
      endcase
    end else if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    // data write routing; latches win over eeprom, busy drops a latch-mapped byte
    nxt_st.r_latch = latch_we;
    nxt_st.r_eeprom = xdata_wr && !st_ff.lmap && eeprom_space_enable;
    nxt_st.r_xram = xdata_wr && !st_ff.lmap && !eeprom_space_enable;
    if (latch_we) begin
      nxt_st.page = xdata_addr[14:7];
    end
    // code read: decode now, memory answers next cycle, mux after that
    nxt_st.rd_pend = code_rd;
    nxt_st.rd_src = st_ff.busy ? SRC_ERR : dec_src;
    nxt_st.code_valid = st_ff.rd_pend;
    nxt_st.code_err = st_ff.rd_pend && st_ff.rd_src == SRC_ERR;
    case (st_ff.rd_src)
      SRC_USER: nxt_st.code_data = user_q;
      SRC_BOOT: nxt_st.code_data = boot_q;
      SRC_EXTRA: nxt_st.code_data = extra_q;
      SRC_SEC:  nxt_st.code_data = {st_ff.sec_hi, `SEC_LO_RESET};
      default:  nxt_st.code_data = 8'h00;
    endcase
    // erase/program sequencer
    case (st_ff.fsm)
      S_IDLE: begin
        if (launch_ok) begin
          nxt_st.busy = 1'b1;
          nxt_st.tgt = fcr_now[`FCR_MODE_HI:`FCR_MODE_LO];
          nxt_st.timer = 12'(`ERASE_CYC - 1);
          nxt_st.idx = 7'h00;
          nxt_st.fsm = S_ERASE;
        end
      end
      S_ERASE: begin
        if (st_ff.timer == 12'h000) begin
          nxt_st.fsm = S_FETCH;
        end else begin
          nxt_st.timer = st_ff.timer - 12'h001;
        end
      end
      S_FETCH: nxt_st.fsm = S_WRITE;
      S_WRITE: begin
        // security byte takes the upper nibble of latch byte 0 only
        if (st_ff.tgt == `SP_SEC && st_ff.idx == 7'h00 && latch_loaded) begin
          nxt_st.sec_hi = latch_q[7:4];
        end
        nxt_st.idx = st_ff.idx + 7'h01;
        if (st_ff.idx == 7'h7F) begin
          nxt_st.timer = 12'(`PROG_CYC - 1);
          nxt_st.fsm = S_PROG;
        end else begin
          nxt_st.fsm = S_FETCH;
        end
      end
      S_PROG: begin
        if (st_ff.timer == 12'h000) begin
          nxt_st.fsm = S_DONE;
        end else begin
          nxt_st.timer = st_ff.timer - 12'h001;
        end
      end
      S_DONE: begin
        nxt_st.busy = 1'b0;
        nxt_st.idx = 7'h00;
        nxt_st.fsm = S_IDLE;
      end
      default: nxt_st.fsm = S_IDLE;
    endcase
    // ready flags registered so every bus output is a flip-flop
    nxt_st.awready = !nxt_st.aw_got && !nxt_st.bvalid;
    nxt_st.wready = !nxt_st.w_got && !nxt_st.bvalid;
    nxt_st.arready = !nxt_st.rvalid;
  end

  // one register for the whole state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
      st_ff.fsm <= S_IDLE;
      st_ff.rd_src <= SRC_ERR;
      st_ff.awready <= 1'b1;
      st_ff.wready <= 1'b1;
      st_ff.arready <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from the state register
  assign s_axi_awready = st_ff.awready;
  assign s_axi_wready  = st_ff.wready;
  assign s_axi_bvalid  = st_ff.bvalid;
  assign s_axi_bresp   = st_ff.bresp;
  assign s_axi_arready = st_ff.arready;
  assign s_axi_rvalid  = st_ff.rvalid;
  assign s_axi_rdata   = st_ff.rdata;
  assign s_axi_rresp   = st_ff.rresp;
  assign code_rdata    = st_ff.code_data;
  assign code_rvalid   = st_ff.code_valid;
  assign code_rerr     = st_ff.code_err;
  assign route_latch   = st_ff.r_latch;
  assign route_eeprom  = st_ff.r_eeprom;
  assign route_xram    = st_ff.r_xram;
  assign flash_busy    = st_ff.busy;

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_busy_on_launch: assert property (
    launch_ok |=> flash_busy ##1 flash_busy)
    else $error("busy not raised on launch");
  a_busy_clears: assert property (st_ff.fsm == S_DONE |=> !flash_busy)
    else $error("busy not cleared at completion");
  a_user_refused: assert property (
    (key_go && !exec_from_boot && !st_ff.busy) |=> !flash_busy)
    else $error("launch from user code started programming");
  a_reserved_idle: assert property (
    (key_go && fcr_now[`FCR_MODE_HI:`FCR_MODE_LO] == 2'b11
     && !st_ff.busy) |=> !flash_busy)
    else $error("reserved space started programming");
  a_lone_key: assert property ((key_arm && !st_ff.busy) |=> !flash_busy)
    else $error("first key alone started programming");
  a_boot_hidden: assert property (
    (code_rd && !st_ff.busy && !exec_from_boot && code_addr >= `BOOT_BASE
     && st_ff.mode == `SP_USER) |-> ##2 code_rerr)
    else $error("user code read boot flash");
  a_boot_unmapped: assert property (
    (code_rd && !st_ff.boot_en && code_addr >= `BOOT_BASE
     && code_addr < `EXTRA_BASE) |-> ##2 (code_rvalid && code_rerr))
    else $error("boot flash visible while unmapped");
  a_latch_wins: assert property (
    (xdata_wr && st_ff.lmap && !st_ff.busy) |=> (route_latch && !route_eeprom))
    else $error("latch map did not win the write");
  a_busy_blocks: assert property (
    (xdata_wr && st_ff.busy) |=> !route_latch)
    else $error("latch written while busy");
  a_last_page: assert property (
    latch_we |=> st_ff.page == $past(xdata_addr[14:7]))
    else $error("page not taken from last latch write");
  a_key_abort: assert property (
    (st_ff.armed && st_ff.retire_cnt == 2'd1 && instr_retire && !wr_fcr)
    |=> !st_ff.armed)
    else $error("launch not aborted after extra instruction");
  a_sec_low_ro: assert property (
    (code_rvalid && !code_rerr && $past(st_ff.rd_src) == SRC_SEC)
    |-> code_rdata[3:0] == `SEC_LO_RESET)
    else $error("security low nibble changed");

  c_launch: cover property (launch_ok);
  c_done: cover property (st_ff.fsm == S_DONE);
  c_refused: cover property (key_go && !exec_from_boot);
  c_extra_read: cover property (code_rvalid
                                && $past(st_ff.rd_src) == SRC_EXTRA);
endmodule
`default_nettype wire

// file: logic/latch_buffer.sv
// column latch page buffer with per-byte loaded marks
`default_nettype none
module latch_buffer #(
  parameter int AW = 7
) (
  input  wire logic          aclk,    // clock
  input  wire logic          aresetn, // sync reset, active low
  input  wire logic          we,      // load one byte
  input  wire logic [AW-1:0] waddr,   // byte offset to load
  input  wire logic [7:0]    wdata,   // byte to load
  input  wire logic [AW-1:0] raddr,   // byte offset to read
  input  wire logic          clear,   // drop all loaded marks
  output logic      [7:0]    rdata,   // latch byte, one cycle late
  output logic               loaded   // mark of that byte
);
  logic [7:0]         mem [0:(1<<AW)-1];
  logic [(1<<AW)-1:0] mark_ff;

  // data array needs no reset, only the marks decide what is written
  always_ff @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

  // marks: a load in the clearing cycle survives
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mark_ff <= '0;
      loaded  <= 1'b0;
    end else begin
      loaded <= mark_ff[raddr];
      if (clear) begin
        mark_ff <= '0;
      end
      if (we) begin
        mark_ff[waddr] <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: verif/core_model.sv
// cpu core stand-in: code fetches, data moves and retire pulses
`default_nettype none
module core_model (
  input  wire logic        aclk,           // clock
  output logic             exec_from_boot, // running from boot flash
  output logic             instr_retire,   // instruction retired pulse
  output logic             code_rd,        // code fetch pulse
  output logic      [15:0] code_addr,      // code fetch address
  output logic             xdata_wr,       // data move pulse
  output logic      [15:0] xdata_addr,     // data move address
  output logic      [7:0]  xdata_wdata     // data move byte
);
  timeunit 1ns;
  timeprecision 1ps;
  // quiet at time zero
  initial begin
    exec_from_boot = 1'b0;
    instr_retire   = 1'b0;
    code_rd        = 1'b0;
    code_addr      = 16'h0000;
    xdata_wr       = 1'b0;
    xdata_addr     = 16'h0000;
    xdata_wdata    = 8'h00;
  end
  // fetch pulse; address inverted after, so no stale value lingers
  task automatic rd(input logic [15:0] a);
    @(posedge aclk);
    code_rd   <= 1'b1;
    code_addr <= a;
    @(posedge aclk);
    code_rd   <= 1'b0;
    code_addr <= ~a;
  endtask
  // one data move by pointer, as a latch load does
  task automatic xw(input logic [15:0] a, input logic [7:0] d);
    @(posedge aclk);
    xdata_wr    <= 1'b1;
    xdata_addr  <= a;
    xdata_wdata <= d;
    @(posedge aclk);
    xdata_wr    <= 1'b0;
    xdata_addr  <= ~a;
    xdata_wdata <= ~d;
  endtask
  // retires only when told: interrupt entries never occur here
  task automatic retire;
    @(posedge aclk);
    instr_retire <= 1'b1;
    @(posedge aclk);
    instr_retire <= 1'b0;
  endtask
  task automatic boot(input logic b);
    @(posedge aclk);
    exec_from_boot <= b;
  endtask
endmodule
`default_nettype wire

// file: verif/test_flash_page_program_control.sv
// self-checking bench of the flash page program controller
`default_nettype none
module test_flash_page_program_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, eeprom_space_enable = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, code_rvalid, code_rerr;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        exec_from_boot, instr_retire, code_rd, xdata_wr;
  logic [15:0] code_addr, xdata_addr;
  logic [7:0]  xdata_wdata, code_rdata, d1, d2;
  logic        route_latch, route_eeprom, route_xram, flash_busy;
  logic [6:0]  pg, off;
  logic [9:0]  exp_rd[$], exp_b[$], exp_code[$], exp_rt[$];
  int          fails = 0, checks_done = 0, seed = 32'h90e0;

  always #12.5 aclk = ~aclk;

  flash_page_program_control flash_page_program_control_inst (.aclk,
    .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .exec_from_boot, .instr_retire, .code_rd, .code_addr, .code_rdata,
    .code_rvalid, .code_rerr, .xdata_wr, .xdata_addr, .xdata_wdata,
    .eeprom_space_enable, .route_latch, .route_eeprom, .route_xram,
    .flash_busy);
  core_model core_inst (.aclk, .exec_from_boot, .instr_retire, .code_rd,
    .code_addr, .xdata_wr, .xdata_addr, .xdata_wdata);

  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [9:0] e, input logic [9:0] s);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  // a wait that used its whole bound ends the run
  task tmo(input int n, input int lim);
    if (n >= lim) begin
      fails++;
      $display("Error wait expected answer seen none");
      tally_and_finish;
    end
  endtask
  function automatic logic [9:0] pop(ref logic [9:0] q[$]);
    return (q.size() != 0) ? q.pop_front() : 10'h3FF;
  endfunction
  // each answer seen is compared with the oldest note of its kind
  always @(posedge aclk) begin
    if (s_axi_bvalid === 1'b1 && s_axi_bready)
      chk("bresp", pop(exp_b), {8'h00, s_axi_bresp});
    if (s_axi_rvalid === 1'b1 && s_axi_rready)
      chk("rdata", pop(exp_rd), {s_axi_rresp, s_axi_rdata[7:0]});
    if (code_rvalid === 1'b1)
      chk("code", pop(exp_code), {1'b0, code_rerr, code_rdata});
    if ((route_latch | route_eeprom | route_xram) === 1'b1)
      chk("route", pop(exp_rt),
          {7'h00, route_latch, route_eeprom, route_xram});
  end

  // write: both halves offered together, each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [7:0] d,
                     input logic [1:0] er = 2'b00);
    int n;
    exp_b.push_back({8'h00, er});
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    tmo(n, 20);
  endtask
  task automatic axr(input logic [7:0] a, input logic [9:0] e);
    int n;
    exp_rd.push_back(e);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    tmo(n, 20);
  endtask
  task automatic cr(input logic [15:0] a, input logic [8:0] e);
    exp_code.push_back({1'b0, e});
    core_inst.rd(a);
  endtask
  task automatic xw(input logic [15:0] a, input logic [7:0] d,
                    input logic [2:0] r);
    if (r != 3'b000) exp_rt.push_back({7'h00, r});
    core_inst.xw(a, d);
  endtask
  // key pair with a chosen number of retired instructions between
  task automatic go(input logic [3:0] m, input int rt);
    axw(8'h00, {4'h5, m});
    repeat (rt) core_inst.retire();
    axw(8'h00, {4'hA, m});
  endtask
  task automatic wait_idle;
    int n;
    for (n = 0; n < 1000 && flash_busy !== 1'b0; n++) @(posedge aclk);
    tmo(n, 1000);
  endtask

  // main sequence: reset, mapping, refused launches, three programs
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    axr(8'h00, 10'h000);
    axr(8'h08, 10'h200);
    axw(8'h08, 8'h00, 2'b10);
    axw(8'h00, 8'h04);
    cr(16'h0000, 9'h00F);
    cr(16'h0100, 9'h100);
    axw(8'h00, 8'h00);
    cr(16'hF800, 9'h100);
    axw(8'h04, 8'h01);
    axr(8'h04, 10'h001);
    cr(16'hFFFF, 9'h100);
    axw(8'h00, 8'h08);
    xw(16'h1234, 8'h11, 3'b100);
    eeprom_space_enable <= 1'b1;
    xw(16'h0001, 8'h22, 3'b100);
    axw(8'h00, 8'h00);
    xw(16'h0002, 8'h33, 3'b010);
    eeprom_space_enable <= 1'b0;
    xw(16'h0003, 8'h44, 3'b001);
    go(4'h8, 1);
    axr(8'h00, 10'h0A8);
    core_inst.boot(1'b1);
    axw(8'h00, 8'hA8);
    axr(8'h00, 10'h0A8);
    go(4'h8, 2);
    axr(8'h00, 10'h0A8);
    go(4'hE, 1);
    axr(8'h00, 10'h0AE);
    pg  = 7'($random(seed));
    off = 7'($random(seed));
    d1  = 8'($random(seed));
    d2  = 8'($random(seed));
    xw({2'b00, pg + 7'h01, off}, d1, 3'b100);
    xw({2'b00, pg, ~off}, d2, 3'b100);
    go(4'h8, 1);
    axr(8'h00, 10'h0A9);
    xw(16'h0000, 8'hFF, 3'b000);
    cr(16'h0000, 9'h100);
    wait_idle;
    axr(8'h00, 10'h0A8);
    axw(8'h00, 8'h00);
    cr({2'b00, pg, off}, {1'b0, d1});
    cr({2'b00, pg, ~off}, {1'b0, d2});
    axw(8'h00, 8'h0C);
    xw(16'h0000, d1, 3'b100);
    go(4'h4, 1);
    wait_idle;
    cr(16'h0000, {1'b0, d1[7:4], 4'hF});
    axw(8'h00, 8'h0A);
    xw({9'h1FF, off}, d2, 3'b100);
    go(4'h2, 1);
    wait_idle;
    cr({9'h1FF, off}, {1'b0, d2});
    repeat (4) @(posedge aclk);
    chk("notes left", 10'h000, 10'(exp_rd.size() + exp_b.size()
        + exp_code.size() + exp_rt.size()));
    tally_and_finish;
  end
endmodule
`default_nettype wire
